// ==== dv/slpt_assertions.sv ====
// Checker: edge timing on the link wires between programmer and sensor.
// Assumes one clock domain; parameters equal those given to the two ends.
`timescale 1ns/1ps
module slpt_assertions
   import slpt_pkg::*;
#(
   parameter int SUP_BIT    = SUP_BIT_CYC,
   parameter int OUT_BIT    = OUT_BIT_CYC,
   parameter int PROG_PULSE = PROG_PULSE_CYC
) (
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic supply_hi,
   input  wire logic supply_prog,
   input  wire logic out_dev_o,
   input  wire logic out_dev_oe_n,
   input  wire logic out_prg_o,
   input  wire logic out_prg_oe_n
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   int   sgap, dgap, pcnt, quiet, acnt;
   logic sup_q, start_q, dev_q, drv_q, first_q, act_q;
   logic stog, drv, dtog, act;
   assign stog = supply_hi != sup_q;
   assign drv  = !out_dev_oe_n;
   assign dtog = drv && drv_q && (out_dev_o != dev_q);
   assign act  = !out_prg_oe_n && out_prg_o;
   // Cycles since the last edge of supply_hi and out_dev_o; sgap starts large so reset looks idle
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sup_q   <= 1'b0;
         start_q <= 1'b0;
         sgap    <= 1000000;
         dev_q   <= 1'b0;
         drv_q   <= 1'b0;
         first_q <= 1'b0;
         dgap    <= 0;
      end else begin
         sup_q   <= supply_hi;
         sgap    <= stog ? 1 : sgap + 1;
         start_q <= stog ? (supply_hi && sgap > 2 * SUP_BIT) : start_q;
         dev_q   <= out_dev_o;
         drv_q   <= drv;
         dgap    <= (dtog || (drv && !drv_q)) ? 1 : dgap + 1;
         first_q <= (drv && !drv_q) || (first_q && !dtog);
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pcnt  <= 0;
         quiet <= 0;
         acnt  <= 0;
         act_q <= 1'b0;
      end else begin
         pcnt  <= supply_prog ? pcnt + 1 : 0;
         quiet <= drv ? 0 : quiet + 1;
         acnt  <= act ? acnt + 1 : 0;
         act_q <= act;
      end
   end
   sequence act_end_s;
      act_q && !act;
   endsequence
   sync_len_a: assert property (stog && start_q |-> sgap == SUP_BIT)
      else $error("sync bit length wrong");
   sup_gap_a: assert property (stog && sgap <= SUP_BIT |-> sgap >= SUP_BIT / 5)
      else $error("supply edge too early");
   ack_len_a: assert property (dtog && first_q |-> dgap == OUT_BIT)
      else $error("acknowledge length wrong");
   out_gap_a: assert property (dtog |-> dgap >= OUT_BIT / 5 && dgap <= OUT_BIT)
      else $error("reply edge spacing wrong");
   prog_len_a: assert property ($fell(supply_prog) |-> pcnt == PROG_PULSE)
      else $error("programming pulse length wrong");
   prog_wait_a: assert property ($rose(supply_prog) |-> quiet >= 10000 && quiet <= 20000)
      else $error("programming delay wrong");
   prog_quiet_a: assert property (supply_prog |-> !stog)
      else $error("supply toggled while programming");
   one_driver_a: assert property (!(drv && !out_prg_oe_n))
      else $error("both ends drive output");
   act_len_a: assert property (act_end_s |-> acnt >= ACT_MIN_CYC && acnt <= ACT_MAX_CYC)
      else $error("activate pulse length wrong");
endmodule : slpt_assertions

// ==== dv/test_supply_line_programming_telegram.sv ====
// Testbench: programmer and sensor facing each other over the link.
// Assumes shortened bit lengths and programming pulse, full-length activate pulse; one 20 MHz clock for both ends.
`timescale 1ns/1ps
module test_supply_line_programming_telegram;
   import slpt_pkg::*;
   localparam int SUPB = 40;
   localparam int OUTB = 60;
   localparam int PPUL = 200;
   logic        clk_i        = 1'b0;
   logic        arst_n_i     = 1'b0;
   logic [3:0]  addr_i       = 4'h0;
   logic [31:0] wdata_i      = 32'h0;
   logic        wr_i         = 1'b0;
   logic        rd_i         = 1'b0;
   logic [31:0] rdata_o;
   logic [7:0]  low_clamp_o;
   logic        active_o;
   logic        prog_req_o;
   logic        erase_req_o;
   logic [31:0] st;
   logic [31:0] d;
   int          mismatches   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   int          prog_seen    = 0;
   int          erase_seen   = 0;
   int          prog_high    = 0;
   int          m_clamp      = 0;
   int          m_active     = 1;
   int          vals[3];
   slpt_if link ();
   slpt_programmer #(.SUP_BIT(SUPB), .PROG_PULSE(PPUL)) slpt_programmer_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   slpt_sensor #(.OUT_BIT(OUTB), .MAX_GAP(2 * SUPB)) slpt_sensor_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .low_clamp_o(low_clamp_o),
      .active_o(active_o), .prog_req_o(prog_req_o), .erase_req_o(erase_req_o));
   slpt_assertions #(.SUP_BIT(SUPB), .OUT_BIT(OUTB), .PROG_PULSE(PPUL)) slpt_assertions_i (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .supply_hi(link.supply_hi),
      .supply_prog(link.supply_prog), .out_dev_o(link.out_dev_o),
      .out_dev_oe_n(link.out_dev_oe_n), .out_prg_o(link.out_prg_o),
      .out_prg_oe_n(link.out_prg_oe_n));
   always #25 clk_i = ~clk_i;
   // Pulse counting and hang guard
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      prog_seen = prog_seen + int'(prog_req_o === 1'b1);
      erase_seen = erase_seen + int'(erase_req_o === 1'b1);
      prog_high = prog_high + int'(link.supply_prog === 1'b1);
      if (cycles == 90000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : bus_rd
   // One telegram, then status polled until the programmer is idle
   task automatic send(input logic [2:0] cmd, input logic [3:0] adr, input logic [13:0] v);
      bus_wr(HOFF_TXDATA, {18'h0, v});
      bus_wr(HOFF_CTRL, {24'h0, 1'b1, cmd, adr});
      for (int k = 0; k < 20000; k++) begin
         bus_rd(HOFF_STATUS, st);
         if (st[0] === 1'b0) break;
      end
      if (st[0] !== 1'b0) begin
         mismatches++;
         close_out();
      end
   endtask : send
   task automatic close_out();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   initial begin
      void'($urandom(32'h4f1790d8));
      vals = '{32'h3fff, 32'h3f00, 0};
      vals[2] = $urandom & 32'h3fff;
      repeat (6) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("low clamp", 32'(m_clamp), {24'h0, low_clamp_o});
      chk("active", 32'(m_active), {31'h0, active_o});
      foreach (vals[i]) begin
         send(CMD_WRITE, ADR_LOW_CLAMP, vals[i][13:0]);
         m_clamp = vals[i] & 32'hff;
         chk("write ack", 32'h1, {31'h0, st[1]});
         chk("low clamp", 32'(m_clamp), {24'h0, low_clamp_o});
         send(CMD_READ, ADR_LOW_CLAMP, 14'h0);
         chk("reply status", 32'h1, {30'h0, st[2:1]});
         bus_rd(HOFF_RDDATA, d);
         chk("read data", 32'(m_clamp), {24'h0, d[13:6]});
      end
      send(CMD_PROGRAM, ADR_LOW_CLAMP, 14'h0);
      chk("program ack", 32'h1, {31'h0, st[1]});
      chk("program pulse", 32'(PPUL), 32'(prog_high));
      send(CMD_ERASE, ADR_LOW_CLAMP, 14'h0);
      chk("erase ack", 32'h1, {31'h0, st[1]});
      chk("prog pulses", 32'h1, 32'(prog_seen));
      chk("erase pulses", 32'h1, 32'(erase_seen));
      send(CMD_WRITE, ADR_DEACTIVATE, DEACT_KEY);
      m_active = 0;
      chk("active", 32'(m_active), {31'h0, active_o});
      send(CMD_WRITE, ADR_LOW_CLAMP, 14'h0055);
      chk("silent ack", 32'h0, {31'h0, st[1]});
      chk("low clamp", 32'(m_clamp), {24'h0, low_clamp_o});
      bus_wr(HOFF_CTRL, 32'h400);
      bus_wr(HOFF_CTRL, 32'h100);
      for (int k = 0; k < 8000 && active_o !== 1'b1; k++) @(posedge clk_i);
      m_active = 1;
      chk("active", 32'(m_active), {31'h0, active_o});
      send(CMD_WRITE, ADR_LOW_CLAMP, 14'h3c55);
      m_clamp = 32'h55;
      chk("write ack", 32'h1, {31'h0, st[1]});
      chk("low clamp", 32'(m_clamp), {24'h0, low_clamp_o});
      close_out();
   end
endmodule : test_supply_line_programming_telegram

// ==== logic/slpt_if.sv ====
// Link between programmer and sensor: supply modulation and output pin.
// Output pin is two-way; the wire level is resolved here from enables.
`timescale 1ns/1ps
interface slpt_if;
   logic supply_hi;       // Supply at high programming level
   logic supply_prog;     // Supply at EEPROM programming level
   logic out_dev_o;
   logic out_dev_oe_n;
   logic out_prg_o;
   logic out_prg_oe_n;
   logic out_line;
   // Pull-down keeps the line low when undriven
   assign out_line = (!out_dev_oe_n && out_dev_o) || (!out_prg_oe_n && out_prg_o);
   modport dev (input supply_hi, input supply_prog, input out_line,
                output out_dev_o, output out_dev_oe_n);
   modport prg (output supply_hi, output supply_prog, input out_line,
                output out_prg_o, output out_prg_oe_n);
endinterface : slpt_if

// ==== logic/slpt_pkg.sv ====
// Shared constants for the supply-line programming telegram link.
// Assumes a 20 MHz system clock on both ends.
package slpt_pkg;
   localparam int          CLK_HZ          = 20000000;
   // Times in microseconds
   localparam int          SUP_BIT_US      = 1750;
   localparam int          OUT_BIT_US      = 3000;
   localparam int          PROG_WAIT_US    = 700;
   localparam int          PROG_PULSE_US   = 100000;
   localparam int          ACT_PULSE_US    = 100;
   localparam int          SUP_BIT_CYC     = SUP_BIT_US * (CLK_HZ / 1000000);
   localparam int          OUT_BIT_CYC     = OUT_BIT_US * (CLK_HZ / 1000000);
   localparam int          PROG_WAIT_CYC   = PROG_WAIT_US * (CLK_HZ / 1000000);
   localparam int          PROG_PULSE_CYC  = PROG_PULSE_US * (CLK_HZ / 1000000);
   localparam int          ACT_PULSE_CYC   = ACT_PULSE_US * (CLK_HZ / 1000000);
   localparam int          ACT_MIN_CYC     = 50 * (CLK_HZ / 1000000);
   localparam int          ACT_MAX_CYC     = 200 * (CLK_HZ / 1000000);
   // Telegram layout
   localparam int          CMD_W           = 3;
   localparam int          ADR_W           = 4;
   localparam int          PAYLOAD_W       = 14;
   localparam int          HDR_BITS        = 1 + CMD_W + 1 + ADR_W + 1;
   localparam int          WR_BITS         = HDR_BITS + PAYLOAD_W + 1;
   localparam int          RD_BITS         = 1 + PAYLOAD_W + 1;
   localparam logic [2:0]  CMD_READ        = 3'h2;
   localparam logic [2:0]  CMD_WRITE       = 3'h3;
   localparam logic [2:0]  CMD_PROGRAM     = 3'h4;
   localparam logic [2:0]  CMD_ERASE       = 3'h5;
   localparam logic [3:0]  ADR_LOW_CLAMP   = 4'h1;
   localparam logic [3:0]  ADR_DEACTIVATE  = 4'hf;
   localparam logic [13:0] DEACT_KEY       = 14'h080f;
   localparam int          LOW_CLAMP_W     = 8;
   localparam logic [7:0]  LOW_CLAMP_RST   = 8'h00;
   localparam int          DEACT_W         = 12;
   // Host command register map
   localparam logic [3:0]  HOFF_CTRL       = 4'h0;
   localparam logic [3:0]  HOFF_STATUS     = 4'h4;
   localparam logic [3:0]  HOFF_RDDATA     = 4'h8;
   localparam logic [3:0]  HOFF_TXDATA     = 4'hc;

   // Parity over n low bits of v counting zeros: odd_one=1 gives header form
   function automatic logic zero_par(input logic [13:0] v, input int n, input logic odd_one);
      int z;
      z = 0;
      for (int i = 0; i < 14; i++) begin
         if (i < n && !v[i]) begin
            z++;
         end
      end
      return odd_one ? z[0] : ~z[0];
   endfunction : zero_par
endpackage : slpt_pkg

// ==== logic/slpt_programmer.sv ====
// Programmer end: sends supply telegrams, decodes replies, drives pulses.
// Assumes sensor output pin is asynchronous; software uses a plain port.
`timescale 1ns/1ps
module slpt_programmer #(
   parameter int SUP_BIT    = slpt_pkg::SUP_BIT_CYC,
   parameter int PROG_PULSE = slpt_pkg::PROG_PULSE_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   slpt_if.prg              link,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic [31:0]      rdata_o
);
   import slpt_pkg::*;

   typedef enum {P_IDLE, P_TX, P_RX, P_WAIT, P_PROG, P_ACT} slpt_pr_e;

   slpt_pr_e    st_reg;
   logic [24:0] tx_reg;
   logic [4:0]  left_reg;
   logic [31:0] cnt_reg;
   logic        lvl_reg;
   logic [2:0]  cmd_reg;
   logic [13:0] txd_reg;
   logic [15:0] rx_reg;
   logic [4:0]  rx_n_reg;
   logic [31:0] per_reg;
   logic        mid_reg;
   logic        ack_reg;
   logic        perr_reg;
   logic [2:0]  in_sync_reg;
   logic        in_lvl_reg;
   logic        pull_reg;
   logic        act_reg;

   wire in_edge = (in_sync_reg[2] == in_sync_reg[1]) && (in_sync_reg[1] != in_lvl_reg);
   wire busy    = st_reg != P_IDLE;

   // Software port: ctrl bits: pull 10, act 8, go 7, cmd 6:4, adr 3:0
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o  <= 32'h0;
         txd_reg  <= 14'h0;
         pull_reg <= 1'b0;
      end else begin
         rdata_o <= 32'h0;
         if (rd_i) begin
            case (addr_i)
               HOFF_STATUS: rdata_o <= {29'h0, perr_reg, ack_reg, busy};
               HOFF_RDDATA: rdata_o <= {18'h0, rx_reg[14:1]};
               HOFF_TXDATA: rdata_o <= {18'h0, txd_reg};
               default:     rdata_o <= 32'h0;
            endcase
         end
         if (wr_i && addr_i == HOFF_TXDATA) begin
            txd_reg <= wdata_i[13:0];
         end
         if (wr_i && addr_i == HOFF_CTRL) begin
            pull_reg <= wdata_i[10];
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_sync_reg <= 3'h0;
         in_lvl_reg  <= 1'b0;
      end else begin
         in_sync_reg <= {in_sync_reg[1:0], link.out_line};
         if (in_edge) begin
            in_lvl_reg <= in_sync_reg[1];
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg   <= P_IDLE;
         tx_reg   <= 25'h0;
         left_reg <= 5'h0;
         cnt_reg  <= 32'h0;
         lvl_reg  <= 1'b0;
         cmd_reg  <= 3'h0;
         rx_reg   <= 16'h0;
         rx_n_reg <= 5'h0;
         per_reg  <= 32'h0;
         mid_reg  <= 1'b0;
         ack_reg  <= 1'b0;
         perr_reg <= 1'b0;
         act_reg  <= 1'b0;
         link.supply_prog <= 1'b0;
      end else begin
         case (st_reg)
            P_IDLE: begin
               if (wr_i && addr_i == HOFF_CTRL && wdata_i[8]) begin
                  act_reg <= 1'b1;
                  cnt_reg <= 32'h0;
                  st_reg  <= P_ACT;
               end else if (wr_i && addr_i == HOFF_CTRL && wdata_i[7]) begin
                  tx_reg <= {1'b0, wdata_i[6:4],
                             zero_par({11'h0, wdata_i[6:4]}, CMD_W, 1'b1), wdata_i[3:0],
                             zero_par({10'h0, wdata_i[3:0]}, ADR_W, 1'b1),
                             txd_reg, zero_par(txd_reg, PAYLOAD_W, 1'b0)};
                  left_reg <= (wdata_i[6:4] == CMD_WRITE) ? 5'(WR_BITS) : 5'(HDR_BITS);
                  cmd_reg  <= wdata_i[6:4];
                  cnt_reg  <= 32'h0;
                  lvl_reg  <= 1'b1;
                  ack_reg  <= 1'b0;
                  perr_reg <= 1'b0;
                  st_reg   <= P_TX;
               end
            end
            P_TX: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (tx_reg[24] && cnt_reg == 32'(SUP_BIT * 13 / 20)) begin
                  lvl_reg <= ~lvl_reg;
               end
               if (cnt_reg == 32'(SUP_BIT - 1)) begin
                  cnt_reg  <= 32'h0;
                  lvl_reg  <= ~lvl_reg;
                  left_reg <= left_reg - 5'h1;
                  tx_reg   <= {tx_reg[23:0], 1'b0};
                  if (left_reg == 5'h1) begin
                     rx_n_reg <= 5'h0;
                     st_reg   <= P_RX;
                  end
               end
            end
            P_RX: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (in_edge && rx_n_reg == 5'h0 && in_sync_reg[1]) begin
                  cnt_reg <= 32'h0;
               end else if (in_edge && rx_n_reg == 5'h0) begin
                  per_reg  <= cnt_reg;
                  ack_reg  <= 1'b1;
                  rx_n_reg <= 5'h1;
                  cnt_reg  <= 32'h0;
                  mid_reg  <= 1'b0;
               end else if (in_edge && cnt_reg * 10 < per_reg * 9 && !mid_reg) begin
                  mid_reg <= 1'b1;
               end else if (in_edge) begin
                  // MSB first, leading bits hold register
                  rx_reg   <= {rx_reg[14:0], mid_reg};
                  rx_n_reg <= rx_n_reg + 5'h1;
                  cnt_reg  <= 32'h0;
                  mid_reg  <= 1'b0;
                  if (rx_n_reg == 5'(RD_BITS - 1)) begin
                     perr_reg <= mid_reg != zero_par(rx_reg[13:0], PAYLOAD_W, 1'b0);
                     st_reg   <= P_IDLE;
                  end
               end else if (rx_n_reg == 5'h1 && cmd_reg != CMD_READ) begin
                  cnt_reg <= 32'h0;
                  st_reg  <= (cmd_reg == CMD_PROGRAM) ? P_WAIT : P_IDLE;
               end else if (cnt_reg > 32'(SUP_BIT * 8)) begin
                  st_reg <= P_IDLE;
               end
            end
            P_WAIT: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg == 32'(PROG_WAIT_CYC - 1)) begin
                  cnt_reg <= 32'h0;
                  link.supply_prog <= 1'b1;
                  st_reg  <= P_PROG;
               end
            end
            P_PROG: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg == 32'(PROG_PULSE - 1)) begin
                  link.supply_prog <= 1'b0;
                  st_reg <= P_IDLE;
               end
            end
            P_ACT: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (cnt_reg == 32'(ACT_PULSE_CYC - 1)) begin
                  act_reg <= 1'b0;
                  st_reg  <= P_IDLE;
               end
            end
            default: st_reg <= P_IDLE;
         endcase
      end
   end

   assign link.supply_hi    = (st_reg == P_TX) ? lvl_reg : 1'b0;
   assign link.out_prg_o    = act_reg;
   assign link.out_prg_oe_n = !(act_reg || pull_reg);
endmodule : slpt_programmer

// ==== logic/slpt_sensor.sv ====
// Sensor end: decodes supply telegrams, replies on the output pin.
// Assumes link pins are asynchronous to clk_i; a pull-down holds the output line.
`timescale 1ns/1ps
module slpt_sensor #(
   parameter int OUT_BIT  = slpt_pkg::OUT_BIT_CYC,
   parameter int MAX_GAP  = 2 * slpt_pkg::SUP_BIT_CYC
) (
   input  wire logic                          clk_i,
   input  wire logic                          arst_n_i,
   slpt_if.dev                                link,
   output logic [slpt_pkg::LOW_CLAMP_W-1:0]   low_clamp_o,
   output logic                               active_o,
   output logic                               prog_req_o,
   output logic                               erase_req_o
);
   import slpt_pkg::*;

   typedef enum {S_IDLE, S_SYNC, S_BIT, S_EXEC, S_TX} slpt_rx_e;

   logic [2:0]  sup_sync_reg;
   logic [2:0]  out_sync_reg;
   logic        sup_lvl_reg;
   logic        out_lvl_reg;
   slpt_rx_e    st_reg;
   logic [31:0] cnt_reg;
   logic [31:0] period_reg;
   logic        mid_seen_reg;
   logic [5:0]  nbits_reg;
   logic [24:0] sh_reg;
   logic [15:0] tx_reg;
   logic [4:0]  tx_left_reg;
   logic [31:0] tx_cnt_reg;
   logic        tx_lvl_reg;
   logic        tx_oe_n_reg;
   logic [31:0] act_cnt_reg;

   wire sup_edge = (sup_sync_reg[2] == sup_sync_reg[1]) && (sup_sync_reg[1] != sup_lvl_reg);
   wire out_edge = (out_sync_reg[2] == out_sync_reg[1]) && (out_sync_reg[1] != out_lvl_reg);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sup_sync_reg <= 3'h0;
         out_sync_reg <= 3'h0;
         sup_lvl_reg  <= 1'b0;
         out_lvl_reg  <= 1'b0;
      end else begin
         sup_sync_reg <= {sup_sync_reg[1:0], link.supply_hi};
         out_sync_reg <= {out_sync_reg[1:0], link.out_line};
         if (sup_edge) begin
            sup_lvl_reg <= sup_sync_reg[1];
         end
         if (out_edge) begin
            out_lvl_reg <= out_sync_reg[1];
         end
      end
   end

   // Decoded fields; header bits sit above the payload in the shifter
   wire [2:0]  f_cmd  = (nbits_reg == 6'(HDR_BITS - 1)) ? sh_reg[8:6] : sh_reg[23:21];
   wire        f_cmd_par  = (nbits_reg == 6'(HDR_BITS - 1)) ? sh_reg[5] : sh_reg[20];
   wire [3:0]  f_adr      = (nbits_reg == 6'(HDR_BITS - 1)) ? sh_reg[4:1] : sh_reg[19:16];
   wire        f_adr_par  = (nbits_reg == 6'(HDR_BITS - 1)) ? sh_reg[0] : sh_reg[15];
   wire [13:0] f_pay      = sh_reg[14:1];
   wire        f_pay_par  = sh_reg[0];
   wire        cmd_par_ok = f_cmd_par == zero_par({11'h0, f_cmd}, CMD_W, 1'b1);
   wire        adr_par_ok = f_adr_par == zero_par({10'h0, f_adr}, ADR_W, 1'b1);
   wire        pay_par_ok = f_pay_par == zero_par(f_pay, PAYLOAD_W, 1'b0);
   wire        is_wr  = f_cmd == CMD_WRITE;

   // Receiver; sync bit is first level hold, with no edge counted
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_reg       <= S_IDLE;
         cnt_reg      <= 32'h0;
         period_reg   <= 32'h0;
         mid_seen_reg <= 1'b0;
         nbits_reg    <= 6'h0;
         sh_reg       <= 25'h0;
      end else begin
         case (st_reg)
            S_IDLE: begin
               if (sup_edge && sup_sync_reg[1]) begin
                  st_reg  <= S_SYNC;
                  cnt_reg <= 32'h0;
               end
            end
            S_SYNC: begin
               cnt_reg <= cnt_reg + 32'h1;
               if (sup_edge) begin
                  period_reg   <= cnt_reg + 32'h1;
                  cnt_reg      <= 32'h0;
                  mid_seen_reg <= 1'b0;
                  nbits_reg    <= 6'h1;
                  st_reg       <= S_BIT;
               end else if (cnt_reg > 32'(MAX_GAP)) begin
                  st_reg <= S_IDLE;
               end
            end
            S_BIT: begin
               cnt_reg <= cnt_reg + 32'h1;
               // mid-bit edge gives one; late edge closes bit
               if (sup_edge && (cnt_reg * 10 < period_reg * 9) && !mid_seen_reg) begin
                  mid_seen_reg <= 1'b1;
               end else if (sup_edge) begin
                  sh_reg       <= {sh_reg[23:0], mid_seen_reg};
                  nbits_reg    <= nbits_reg + 6'h1;
                  cnt_reg      <= 32'h0;
                  mid_seen_reg <= 1'b0;
               end else if (cnt_reg > period_reg + (period_reg >> 1)) begin
                  // header end without more edges; write length
                  st_reg <= (nbits_reg == 6'(HDR_BITS) || nbits_reg == 6'(WR_BITS))
                            ? S_EXEC : S_IDLE;
                  nbits_reg <= nbits_reg - 6'h1;
               end
            end
            S_EXEC: begin
               st_reg <= S_IDLE;
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end

   wire good = cmd_par_ok && adr_par_ok
               && (!is_wr || (pay_par_ok && nbits_reg == 6'(WR_BITS - 1)));
   wire exec = (st_reg == S_EXEC) && good && active_o;

   // low clamp register; trailing bits kept
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_clamp_o <= LOW_CLAMP_RST;
      end else if (exec && is_wr && f_adr == ADR_LOW_CLAMP) begin
         low_clamp_o <= f_pay[LOW_CLAMP_W-1:0];
      end
   end

   // deactivate key; activate pulse on the output line
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         active_o    <= 1'b1;
         act_cnt_reg <= 32'h0;
      end else begin
         if (out_lvl_reg && tx_oe_n_reg) begin
            act_cnt_reg <= act_cnt_reg + 32'h1;
         end else begin
            act_cnt_reg <= 32'h0;
         end
         if (exec && is_wr && f_adr == ADR_DEACTIVATE
             && f_pay[DEACT_W-1:0] == DEACT_KEY[DEACT_W-1:0]) begin
            active_o <= 1'b0;
         end else if (!active_o && out_edge && !out_sync_reg[1]
                      && act_cnt_reg >= 32'(ACT_MIN_CYC) && act_cnt_reg <= 32'(ACT_MAX_CYC)) begin
            active_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prog_req_o  <= 1'b0;
         erase_req_o <= 1'b0;
      end else begin
         prog_req_o  <= exec && f_cmd == CMD_PROGRAM;
         erase_req_o <= exec && f_cmd == CMD_ERASE;
      end
   end

   // Transmitter: ack alone or ack, data, parity
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_reg      <= 16'h0;
         tx_left_reg <= 5'h0;
         tx_cnt_reg  <= 32'h0;
         tx_lvl_reg  <= 1'b0;
         tx_oe_n_reg <= 1'b1;
      end else if (exec && f_cmd != 3'h0 && f_cmd <= CMD_ERASE && f_cmd != 3'h1) begin
         // register sits in leading bits of the reply
         tx_reg      <= (f_cmd == CMD_READ && f_adr == ADR_LOW_CLAMP)
                        ? {1'b0, low_clamp_o, 7'h0} : 16'h0;
         tx_left_reg <= (f_cmd == CMD_READ) ? 5'(RD_BITS) : 5'h1;
         tx_cnt_reg  <= 32'h0;
         tx_lvl_reg  <= 1'b1;
         tx_oe_n_reg <= 1'b0;
      end else if (tx_left_reg != 5'h0) begin
         tx_cnt_reg <= tx_cnt_reg + 32'h1;
         // one bit mid toggle at 65 percent
         if (tx_reg[15] && tx_cnt_reg == 32'(OUT_BIT * 13 / 20)) begin
            tx_lvl_reg <= ~tx_lvl_reg;
         end
         // fixed reply period; edge at bit end
         if (tx_cnt_reg == 32'(OUT_BIT - 1)) begin
            tx_cnt_reg  <= 32'h0;
            tx_lvl_reg  <= ~tx_lvl_reg;
            tx_left_reg <= tx_left_reg - 5'h1;
            tx_reg      <= (tx_left_reg == 5'(RD_BITS))
                           ? {tx_reg[14:1], zero_par(tx_reg[14:1], PAYLOAD_W, 1'b0), 1'b0}
                           : {tx_reg[14:0], 1'b0};
         end
      end else begin
         tx_lvl_reg  <= 1'b0;
         tx_oe_n_reg <= 1'b1;
      end
   end

   assign link.out_dev_o    = tx_lvl_reg;
   assign link.out_dev_oe_n = tx_oe_n_reg;
endmodule : slpt_sensor
